//--- verilog/cda_defines.vh
// Purpose: constants for the core decode and addressing unit
// Assumes: included by cda_decode_unit.v
// Notes: opcode and field layout of the instruction word live here
`ifndef CDA_DEFINES_VH
`define CDA_DEFINES_VH

// register port offsets
`define CDA_REG_EXEC_ADDR 8'h00
`define CDA_REG_DEC_ADDR 8'h04
`define CDA_REG_DISCARD 8'h08
`define CDA_REG_CONTROL 8'h0c
`define CDA_REG_VECTOR_BASE 8'h10
`define CDA_REG_STATUS 8'h14
`define CDA_REG_SAVED_ADDR 8'h18

// control and status bits
`define CDA_CTL_MASTER_EN 0
`define CDA_STS_FAULT_PEND 0
`define CDA_STS_BAD_OP 1
`define CDA_STS_BUSY 2

// reset values
`define CDA_RST_MASTER_EN 1'b0
`define CDA_RST_VECTOR_BASE 20'h00000

// misaligned-data fault offset from the vector base (vector 5)
`define CDA_FAULT_OFFSET 12'h050

// instruction fields
`define CDA_F_OP 31:26
`define CDA_F_DST 25:20
`define CDA_F_S1 19:14
`define CDA_F_S2 13:8
`define CDA_F_DISP 13:0
`define CDA_F_CONST16 15:0
`define CDA_F_CONST25 24:0

// operand selectors above the general registers, and the fixed general-register destination of SETLI
`define CDA_SEL_DISCARD 6'h20
`define CDA_SEL_EXEC 6'h21
`define CDA_SEL_DEC 6'h22
`define CDA_SHIFT_IMM_DST 6'h03

// opcodes
`define CDA_OP_LB 6'h01
`define CDA_OP_LBU 6'h02
`define CDA_OP_LHW 6'h03
`define CDA_OP_LHWU 6'h04
`define CDA_OP_LW 6'h05
`define CDA_OP_LXB 6'h06
`define CDA_OP_LXH 6'h07
`define CDA_OP_LXW 6'h08
`define CDA_OP_SB 6'h09
`define CDA_OP_SHW 6'h0a
`define CDA_OP_SW 6'h0b
`define CDA_OP_SWAP 6'h0c
`define CDA_OP_SMUL_LOW 6'h0d
`define CDA_OP_UMUL_LOW 6'h0e
`define CDA_OP_MUL16 6'h0f
`define CDA_OP_MUL32 6'h10
`define CDA_OP_MULU16 6'h11
`define CDA_OP_MULU32 6'h12
`define CDA_OP_SETIH 6'h14
`define CDA_OP_SETLI 6'h15

// access sizes
`define CDA_SZ_BYTE 2'h0
`define CDA_SZ_HALF 2'h1
`define CDA_SZ_WORD 2'h2

`endif

//--- verilog/cda_decode_unit.v
// Purpose: decode, effective address, alignment and multiply core
// Assumes: memory answers each request with memAck, one or more cycles later
// Notes: gpr array has no reset; control state does
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`include "cda_defines.vh"
`default_nettype none

module cda_decode_unit (
    // clock and reset
    input wire core_clk,
    input wire rst_b,
    // register port
    input wire [7:0] busAddr,
    input wire [31:0] busWdata,
    input wire busWr,
    input wire busRd,
    output wire [31:0] busRdata,
    // instruction stream
    input wire instValid,
    input wire [31:0] instWord,
    input wire [31:0] instAddr,
    output wire instReady,
    // data memory
    output wire memReq,
    output wire memWr,
    output wire [31:0] memAddr,
    output wire [3:0] memByteEn,
    output wire [31:0] memWdata,
    input wire memAck,
    input wire [31:0] memRdata,
    // fault dispatch
    output wire faultReq,
    output wire [31:0] faultVector,
    input wire faultAck
);

    localparam [1:0] S_IDLE = 2'd0;
    localparam [1:0] S_MEM = 2'd1;
    localparam [1:0] S_SWAPW = 2'd2;
    localparam [1:0] S_MUL = 2'd3;

    reg [31:0] gpr [0:31];
    reg [1:0] state_reg;
    reg decValid_reg;
    reg [31:0] decWord_reg;
    reg [31:0] decAddr_reg;
    reg [31:0] execAddr_reg;
    reg instReady_reg;
    reg [31:0] busRdata_reg;
    reg memReq_reg;
    reg memWr_reg;
    reg [31:0] memAddr_reg;
    reg [3:0] memByteEn_reg;
    reg [31:0] memWdata_reg;
    reg faultReq_reg;
    reg [31:0] faultVector_reg;
    reg faultPend_reg;
    reg badOp_reg;
    reg masterEn_reg;
    reg [19:0] vectorBase_reg;
    reg [31:0] savedAddr_reg;
    reg [1:0] sizeHold_reg;
    reg sgnHold_reg;
    reg rdHold_reg;
    reg swapHold_reg;
    reg [1:0] offHold_reg;
    reg [5:0] dstHold_reg;
    reg [31:0] mulA_reg;
    reg [31:0] mulB_reg;
    reg mulSgn_reg;

    // decoded fields, one fixed word per instruction
    wire [5:0] fOp = decWord_reg[`CDA_F_OP];
    wire [5:0] fDst = decWord_reg[`CDA_F_DST];
    wire [5:0] fS1 = decWord_reg[`CDA_F_S1];
    wire [5:0] fS2 = decWord_reg[`CDA_F_S2];
    wire [13:0] fDisp = decWord_reg[`CDA_F_DISP];

    function [31:0] readSrc;
        input [5:0] sel;
        begin
            if (sel < 6'h20) begin
                readSrc = gpr[sel[4:0]];
            end else if (sel == `CDA_SEL_EXEC) begin
                readSrc = {execAddr_reg[31:2], 2'b00};
            end else if (sel == `CDA_SEL_DEC) begin
                readSrc = {decAddr_reg[31:2], 2'b00};
            end else begin
                readSrc = 32'h00000000;
            end
        end
    endfunction

    wire [31:0] srcA = readSrc(fS1);
    wire [31:0] srcB = readSrc(fS2);
    wire take = decValid_reg && (state_reg == S_IDLE);

    reg isLoad;
    reg isIdx;
    reg isStore;
    reg isSwap;
    reg isSgn;
    reg isMul;
    reg mulSgn;
    reg badMul;
    reg [1:0] size;

    always @* begin
        isLoad = 1'b0;
        isIdx = 1'b0;
        isStore = 1'b0;
        isSwap = 1'b0;
        isSgn = 1'b0;
        isMul = 1'b0;
        mulSgn = 1'b0;
        badMul = 1'b0;
        size = `CDA_SZ_WORD;
        case (fOp)
            `CDA_OP_LB: begin
                isLoad = 1'b1;
                isSgn = 1'b1;
                size = `CDA_SZ_BYTE;
            end
            `CDA_OP_LBU: begin
                isLoad = 1'b1;
                size = `CDA_SZ_BYTE;
            end
            `CDA_OP_LHW: begin
                isLoad = 1'b1;
                isSgn = 1'b1;
                size = `CDA_SZ_HALF;
            end
            `CDA_OP_LHWU: begin
                isLoad = 1'b1;
                size = `CDA_SZ_HALF;
            end
            `CDA_OP_LW: isLoad = 1'b1;
            `CDA_OP_LXB: begin
                isLoad = 1'b1;
                isIdx = 1'b1;
                isSgn = 1'b1;
                size = `CDA_SZ_BYTE;
            end
            `CDA_OP_LXH: begin
                isLoad = 1'b1;
                isIdx = 1'b1;
                isSgn = 1'b1;
                size = `CDA_SZ_HALF;
            end
            `CDA_OP_LXW: begin
                isLoad = 1'b1;
                isIdx = 1'b1;
            end
            `CDA_OP_SB: begin
                isStore = 1'b1;
                size = `CDA_SZ_BYTE;
            end
            `CDA_OP_SHW: begin
                isStore = 1'b1;
                size = `CDA_SZ_HALF;
            end
            `CDA_OP_SW: isStore = 1'b1;
            `CDA_OP_SWAP: isSwap = 1'b1;
            `CDA_OP_SMUL_LOW: begin
                isMul = 1'b1;
                mulSgn = 1'b1;
            end
            `CDA_OP_UMUL_LOW: isMul = 1'b1;
            `CDA_OP_MUL16, `CDA_OP_MUL32, `CDA_OP_MULU16, `CDA_OP_MULU32: begin
                badMul = 1'b1;
            end
            default: begin
                isLoad = 1'b0;
            end
        endcase
    end

    // base plus index, or base plus displacement for loads, stores, swap
    wire [31:0] offSel = isIdx ? srcB : {{18{fDisp[13]}}, fDisp};
    wire [31:0] effectiveAddress = srcA + offSel;
    wire isMem = isLoad | isStore | isSwap;
    wire misaligned = ((size == `CDA_SZ_HALF) && effectiveAddress[0]) ||
        ((size == `CDA_SZ_WORD) && (effectiveAddress[1:0] != 2'b00));
    wire faultSet = take && isMem && misaligned;

    // big-endian lanes: byte at offset 0 sits in bits 31:24
    wire [1:0] addrLo = effectiveAddress[1:0];
    wire [4:0] stShift = (size == `CDA_SZ_BYTE) ? {~addrLo, 3'b000} :
        (size == `CDA_SZ_HALF) ? {~addrLo[1], 4'h0} : 5'h00;
    wire [31:0] stData = (size == `CDA_SZ_BYTE) ? {24'h000000, srcB[7:0]} :
        (size == `CDA_SZ_HALF) ? {16'h0000, srcB[15:0]} : srcB;
    wire [3:0] stBe = (size == `CDA_SZ_BYTE) ? (4'h8 >> addrLo) :
        (size == `CDA_SZ_HALF) ? (4'hc >> addrLo) : 4'hf;

    wire [4:0] ldShift = (sizeHold_reg == `CDA_SZ_BYTE) ? {~offHold_reg, 3'b000} :
        (sizeHold_reg == `CDA_SZ_HALF) ? {~offHold_reg[1], 4'h0} : 5'h00;
    wire [31:0] lane = memRdata >> ldShift;
    wire [31:0] loadVal = (sizeHold_reg == `CDA_SZ_BYTE) ?
        {{24{sgnHold_reg & lane[7]}}, lane[7:0]} :
        (sizeHold_reg == `CDA_SZ_HALF) ?
        {{16{sgnHold_reg & lane[15]}}, lane[15:0]} : lane;

    // 16x16 low multiply, result in the second cycle
    wire signed [31:0] prodS = $signed(mulA_reg[15:0]) * $signed(mulB_reg[15:0]);
    wire [31:0] prodU = mulA_reg[15:0] * mulB_reg[15:0];

    reg wbEn;
    reg [5:0] wbIdx;
    reg [31:0] wbData;

    always @* begin
        wbEn = 1'b0;
        wbIdx = fDst;
        wbData = 32'h00000000;
        if (take && (fOp == `CDA_OP_SETIH)) begin
            wbEn = 1'b1;
            wbData = {decWord_reg[`CDA_F_CONST16], 16'h0000};
        end else if (take && (fOp == `CDA_OP_SETLI)) begin
            wbEn = 1'b1;
            wbIdx = `CDA_SHIFT_IMM_DST;
            wbData = {decWord_reg[`CDA_F_CONST25], 7'h00};
        end else if (state_reg == S_MUL) begin
            wbEn = 1'b1;
            wbIdx = dstHold_reg;
            wbData = mulSgn_reg ? prodS : prodU;
        end else if ((state_reg == S_MEM) && memAck && rdHold_reg) begin
            wbEn = 1'b1;
            wbIdx = dstHold_reg;
            wbData = loadVal;
        end
    end

    // only the general registers take results
    always @(posedge core_clk) begin
        if (wbEn && (wbIdx < 6'h20)) begin
            gpr[wbIdx[4:0]] <= wbData;
        end
    end

    wire decValid_next = (decValid_reg && !take) || (instValid && instReady_reg);
    wire faultPend_next = faultSet || (faultPend_reg && !faultAck);
    wire ctlWr = busWr && (busAddr == `CDA_REG_CONTROL);
    wire masterEn_next = faultAck ? 1'b0 :
        ctlWr ? busWdata[`CDA_CTL_MASTER_EN] : masterEn_reg;
    wire badOpClr = busWr && (busAddr == `CDA_REG_STATUS) && busWdata[`CDA_STS_BAD_OP];

    reg [31:0] busRead;

    always @* begin
        if (busAddr == `CDA_REG_EXEC_ADDR) begin
            busRead = {execAddr_reg[31:2], 2'b00};
        end else if (busAddr == `CDA_REG_DEC_ADDR) begin
            busRead = {decAddr_reg[31:2], 2'b00};
        end else if (busAddr == `CDA_REG_CONTROL) begin
            busRead = {31'h00000000, masterEn_reg};
        end else if (busAddr == `CDA_REG_VECTOR_BASE) begin
            busRead = {vectorBase_reg, 12'h000};
        end else if (busAddr == `CDA_REG_STATUS) begin
            busRead = {29'h00000000, (state_reg != S_IDLE), badOp_reg, faultPend_reg};
        end else if (busAddr == `CDA_REG_SAVED_ADDR) begin
            busRead = savedAddr_reg;
        end else begin
            busRead = 32'h00000000;
        end
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= S_IDLE;
            decValid_reg <= 1'b0;
            decWord_reg <= 32'h00000000;
            decAddr_reg <= 32'h00000000;
            execAddr_reg <= 32'h00000000;
            instReady_reg <= 1'b0;
            busRdata_reg <= 32'h00000000;
            memReq_reg <= 1'b0;
            memWr_reg <= 1'b0;
            memAddr_reg <= 32'h00000000;
            memByteEn_reg <= 4'h0;
            memWdata_reg <= 32'h00000000;
            faultReq_reg <= 1'b0;
            faultVector_reg <= 32'h00000000;
            faultPend_reg <= 1'b0;
            badOp_reg <= 1'b0;
            masterEn_reg <= `CDA_RST_MASTER_EN;
            vectorBase_reg <= `CDA_RST_VECTOR_BASE;
            savedAddr_reg <= 32'h00000000;
            sizeHold_reg <= `CDA_SZ_WORD;
            sgnHold_reg <= 1'b0;
            rdHold_reg <= 1'b0;
            swapHold_reg <= 1'b0;
            offHold_reg <= 2'b00;
            dstHold_reg <= 6'h00;
            mulA_reg <= 32'h00000000;
            mulB_reg <= 32'h00000000;
            mulSgn_reg <= 1'b0;
        end else begin
            // decode stage
            decValid_reg <= decValid_next;
            instReady_reg <= !decValid_next;
            if (instValid && instReady_reg) begin
                decWord_reg <= instWord;
                decAddr_reg <= instAddr;
            end
            // register port; address registers ignore writes
            busRdata_reg <= busRd ? busRead : 32'h00000000;
            if (busWr && (busAddr == `CDA_REG_VECTOR_BASE)) begin
                vectorBase_reg <= busWdata[31:12];
            end
            masterEn_reg <= masterEn_next;
            badOp_reg <= (take && badMul) || (badOp_reg && !badOpClr);
            // fault request held until accepted, only while enabled
            faultPend_reg <= faultPend_next;
            faultReq_reg <= faultPend_next && masterEn_next;
            faultVector_reg <= {vectorBase_reg, `CDA_FAULT_OFFSET};
            if (faultAck && faultReq_reg) begin
                savedAddr_reg <= {execAddr_reg[31:2], 2'b00};
            end
            memReq_reg <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (take) begin
                        execAddr_reg <= decAddr_reg;
                        if (isMem && !misaligned) begin
                            memReq_reg <= 1'b1;
                            memWr_reg <= isStore;
                            memAddr_reg <= effectiveAddress;
                            memByteEn_reg <= isSwap ? 4'hf : stBe;
                            memWdata_reg <= stData << stShift;
                            sizeHold_reg <= size;
                            sgnHold_reg <= isSgn;
                            rdHold_reg <= isLoad | isSwap;
                            swapHold_reg <= isSwap;
                            offHold_reg <= addrLo;
                            dstHold_reg <= isSwap ? fS2 : fDst;
                            state_reg <= S_MEM;
                        end else if (isMul) begin
                            mulA_reg <= srcA;
                            mulB_reg <= srcB;
                            mulSgn_reg <= mulSgn;
                            dstHold_reg <= fDst;
                            state_reg <= S_MUL;
                        end
                    end
                end
                S_MEM: begin
                    if (memAck) begin
                        if (swapHold_reg) begin
                            memReq_reg <= 1'b1;
                            memWr_reg <= 1'b1;
                            state_reg <= S_SWAPW;
                        end else begin
                            state_reg <= S_IDLE;
                        end
                    end
                end
                S_SWAPW: begin
                    if (memAck) begin
                        state_reg <= S_IDLE;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    assign busRdata = busRdata_reg;
    assign instReady = instReady_reg;
    assign memReq = memReq_reg;
    assign memWr = memWr_reg;
    assign memAddr = memAddr_reg;
    assign memByteEn = memByteEn_reg;
    assign memWdata = memWdata_reg;
    assign faultReq = faultReq_reg;
    assign faultVector = faultVector_reg;

endmodule
`default_nettype wire

//--- tb/cda_mem_model.sv
// Purpose: behavioural memory on the far side of the data port
// Assumes: one request outstanding, byte enables big-endian
// Notes: answer delay set by ackDelay; read data scrambles when idle
`timescale 1ns/1ps
`default_nettype none
module cda_mem_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // request
    input wire logic memReq,
    input wire logic memWr,
    input wire logic [31:0] memAddr,
    input wire logic [3:0] memByteEn,
    input wire logic [31:0] memWdata,
    input wire logic [3:0] ackDelay,
    // answer
    output logic memAck,
    output logic [31:0] memRdata
);
    logic [31:0] mem [0:255];
    logic [3:0] waitCnt;
    logic busy;
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            memAck <= 1'b0;
            memRdata <= 32'h0;
            busy <= 1'b0;
            waitCnt <= 4'h0;
        end else begin
            memAck <= 1'b0;
            memRdata <= ~memRdata;
            if (memReq) begin
                busy <= 1'b1;
                waitCnt <= ackDelay;
            end else if (busy && waitCnt != 4'h0) begin
                waitCnt <= waitCnt - 4'h1;
            end else if (busy) begin
                busy <= 1'b0;
                memAck <= 1'b1;
                if (!memWr) memRdata <= mem[memAddr[9:2]];
                for (int b = 0; b < 4; b++) begin
                    if (memWr && memByteEn[b]) mem[memAddr[9:2]][8*b+:8] <= memWdata[8*b+:8];
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/cda_decode_props.sv
// Purpose: port checks for the decode unit
// Assumes: bound to cda_decode_unit
// Notes: single clock, asynchronous low reset
`timescale 1ns/1ps
`default_nettype none
module cda_decode_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] busAddr,
    input wire logic busRd,
    input wire logic [31:0] busRdata,
    // instruction stream
    input wire logic instValid,
    input wire logic instReady,
    // data memory
    input wire logic memReq,
    input wire logic [31:0] memAddr,
    input wire logic [3:0] memByteEn,
    input wire logic memAck,
    // fault dispatch
    input wire logic faultReq,
    input wire logic [31:0] faultVector,
    input wire logic faultAck
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    rdata_idle_a: assert property (!$past(busRd) |-> busRdata == 32'h0)
        else $error("read data not idle");
    exec_low_a: assert property (
        $past(busRd) && $past(busAddr) == 8'h00 |-> busRdata[1:0] == 2'h0)
        else $error("execute address low bits set");
    dec_low_a: assert property (
        $past(busRd) && $past(busAddr) == 8'h04 |-> busRdata[1:0] == 2'h0)
        else $error("decode address low bits set");
    vec_offset_a: assert property ($past(rst_b) |-> faultVector[11:0] == 12'h050)
        else $error("fault vector offset wrong");
    word_align_a: assert property (
        memReq && memByteEn == 4'hf |-> memAddr[1:0] == 2'h0)
        else $error("misaligned word request");
    half_lane_a: assert property (
        memReq && $countones(memByteEn) == 2 |->
        !memAddr[0] && memByteEn == (memAddr[1] ? 4'h3 : 4'hc))
        else $error("half-word lanes or alignment wrong");
    byte_lane_a: assert property (
        memReq && $onehot(memByteEn) |-> memByteEn == 4'h8 >> memAddr[1:0])
        else $error("byte lane wrong");
    fault_hold_a: assert property (faultReq && !faultAck |=> faultReq)
        else $error("fault request dropped before ack");
    fault_drop_a: assert property (faultReq && faultAck |=> !faultReq)
        else $error("fault request kept after ack");
    take_drop_a: assert property (instValid && instReady |=> !instReady)
        else $error("two words taken back to back");
    req_pulse_a: assert property (memReq && !memAck |=> !memReq)
        else $error("second request while one outstanding");
endmodule
bind cda_decode_unit cda_decode_props chk (.core_clk(core_clk), .rst_b(rst_b),
    .busAddr(busAddr), .busRd(busRd), .busRdata(busRdata), .instValid(instValid),
    .instReady(instReady), .memReq(memReq), .memAddr(memAddr), .memByteEn(memByteEn),
    .memAck(memAck), .faultReq(faultReq), .faultVector(faultVector), .faultAck(faultAck));
`default_nettype wire

//--- tb/cda_decode_unit_tb_top.sv
// Purpose: self-checking bench for the decode unit
// Assumes: memory model on the data port
// Notes: results checked through stores into the model
`timescale 1ns/1ps
`default_nettype none
module cda_decode_unit_tb_top;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic busWr = 1'b0;
    logic busRd = 1'b0;
    logic instValid = 1'b0;
    logic faultAck = 1'b0;
    logic [7:0] busAddr = 8'h00;
    logic [31:0] busWdata = 32'h0;
    logic [31:0] instWord = 32'h0;
    logic [31:0] instAddr = 32'h0;
    logic [3:0] ackDelay = 4'h0;
    logic instReady, memReq, memWr, memAck, faultReq;
    logic [31:0] busRdata, memAddr, memWdata, memRdata, faultVector, rdv, nextAddr, lastAddr;
    logic [3:0] memByteEn;
    logic [5:0] lop [8] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08};
    logic [19:0] llo [8] = '{20'h40, 20'h43, 20'h42, 20'h40, 20'h40, 20'h300, 20'h300, 20'h300};
    logic [31:0] lexp [8] = '{32'hffffff81, 32'hb4, 32'hffffa3b4, 32'h8192, 32'h8192a3b4,
        32'h11, 32'h1122, 32'h11223344};
    int n_mismatch = 0;
    int cmp_count = 0;
    int nReq = 0;
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) if (memReq === 1'b1) nReq++;
    cda_decode_unit dut (.core_clk(core_clk), .rst_b(rst_b), .busAddr(busAddr),
        .busWdata(busWdata), .busWr(busWr), .busRd(busRd), .busRdata(busRdata),
        .instValid(instValid), .instWord(instWord), .instAddr(instAddr), .instReady(instReady),
        .memReq(memReq), .memWr(memWr), .memAddr(memAddr), .memByteEn(memByteEn),
        .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata), .faultReq(faultReq),
        .faultVector(faultVector), .faultAck(faultAck));
    cda_mem_model mem0 (.core_clk(core_clk), .rst_b(rst_b), .memReq(memReq), .memWr(memWr),
        .memAddr(memAddr), .memByteEn(memByteEn), .memWdata(memWdata), .ackDelay(ackDelay),
        .memAck(memAck), .memRdata(memRdata));
    function automatic logic [31:0] w(input logic [5:0] op, input logic [5:0] d,
        input logic [19:0] lo);
        return {op, d, lo};
    endfunction
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
        cmp_count++;
        if (got !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, e, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        busWr <= 1'b1;
        busAddr <= a;
        busWdata <= d;
        @(posedge core_clk);
        busWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        busRd <= 1'b1;
        busAddr <= a;
        @(posedge core_clk);
        busRd <= 1'b0;
        #1 d = busRdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a, rdv);
        chk($sformatf("reg %h", a), e, rdv);
    endtask
    task automatic cm(input logic [31:0] a, input logic [31:0] e);
        chk($sformatf("mem %h", a), e, mem0.mem[a[9:2]]);
    endtask
    // offer one word, then poll status until the unit is idle
    task automatic ex(input logic [31:0] word);
        int n;
        @(posedge core_clk);
        instValid <= 1'b1;
        instWord <= word;
        // low bits set so the address registers must mask them
        instAddr <= nextAddr | 32'h3;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (instReady !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        @(posedge core_clk);
        instValid <= 1'b0;
        lastAddr = nextAddr;
        nextAddr = nextAddr + 32'h4;
        do begin
            rd(8'h14, rdv);
            n++;
        end while (rdv[2] !== 1'b0 && n < 100);
        if (n >= 100) n_mismatch++;
    endtask
    task automatic ack;
        @(posedge core_clk);
        faultAck <= 1'b1;
        @(posedge core_clk);
        faultAck <= 1'b0;
        @(posedge core_clk);
        #1 chk("faultReq", 32'h0, {31'h0, faultReq});
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200us;
        n_mismatch++;
        finish_test;
    end
    initial begin
        int n;
        for (int i = 0; i < 256; i++) mem0.mem[i] = 32'h0;
        mem0.mem[8'h10] = 32'h8192a3b4;
        mem0.mem[8'h20] = 32'h11223344;
        mem0.mem[8'h50] = 32'h8192a3b4;
        nextAddr = 32'h100;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        rc(8'h0c, 32'h0);
        rc(8'h10, 32'h0);
        wr(8'h10, 32'h12345fff);
        rc(8'h10, 32'h12345000);
        rc(8'h30, 32'h0);
        $display("test registers done");
        ex(w(6'h14, 6'd0, 20'h0));
        ex(w(6'h15, 6'd0, 20'h1));
        ex(w(6'h14, 6'd7, 20'ha5c3));
        ex(w(6'h14, 6'h20, 20'hbeef));
        ex(w(6'h0b, 6'd0, {6'd0, 6'd0, 8'h70}));
        cm(32'h70, 32'h0);
        ex(w(6'h0b, 6'd0, {6'd0, 6'd7, 8'h60}));
        cm(32'h760, 32'ha5c30000);
        rc(8'h00, lastAddr);
        rc(8'h04, lastAddr);
        wr(8'h00, 32'hffffffff);
        wr(8'h04, 32'hffffffff);
        rc(8'h00, lastAddr);
        rc(8'h04, lastAddr);
        $display("test immediates done");
        foreach (lop[i]) begin
            ex(w(lop[i], 6'd5, llo[i]));
            ex(w(6'h0b, 6'd0, {6'd0, 6'd5, 8'h20}));
            cm(32'h520, lexp[i]);
        end
        ex(w(6'h09, 6'd0, {6'd0, 6'd5, 8'h31}));
        ex(w(6'h0a, 6'd0, {6'd0, 6'd5, 8'h36}));
        cm(32'h530, 32'h00440000);
        cm(32'h534, 32'h00003344);
        $display("test loads done");
        ackDelay <= 4'h3;
        ex(w(6'h0c, 6'd0, {6'd0, 6'd5, 8'h40}));
        ex(w(6'h0b, 6'd0, {6'd0, 6'd5, 8'h20}));
        ackDelay <= 4'h0;
        cm(32'h540, 32'h11223344);
        cm(32'h520, 32'h8192a3b4);
        $display("test swap done");
        ex(w(6'h0d, 6'd6, {6'd5, 6'd3, 8'h0}));
        ex(w(6'h0b, 6'd0, {6'd0, 6'd6, 8'h20}));
        cm(32'h620, 32'hffd1da00);
        ex(w(6'h0e, 6'd6, {6'd5, 6'd3, 8'h0}));
        for (logic [5:0] op = 6'h0f; op <= 6'h12; op++) ex(w(op, 6'd6, {6'd5, 6'd3, 8'h0}));
        ex(w(6'h0b, 6'd0, {6'd0, 6'd6, 8'h20}));
        cm(32'h620, 32'h0051da00);
        rc(8'h14, 32'h2);
        wr(8'h14, 32'h2);
        rc(8'h14, 32'h0);
        $display("test multiply done");
        wr(8'h0c, 32'h1);
        n = nReq;
        ex(w(6'h05, 6'd7, 20'h42));
        chk("faultReq", 32'h1, {31'h0, faultReq});
        chk("faultVector", 32'h12345050, faultVector);
        chk("requests", n, nReq);
        ack;
        rc(8'h0c, 32'h0);
        rc(8'h18, lastAddr);
        n = nReq;
        ex(w(6'h0a, 6'd0, {6'd0, 6'd5, 8'h23}));
        chk("faultReq", 32'h0, {31'h0, faultReq});
        chk("requests", n, nReq);
        cm(32'h520, 32'h8192a3b4);
        rc(8'h14, 32'h1);
        wr(8'h0c, 32'h1);
        @(posedge core_clk);
        #1 chk("faultReq", 32'h1, {31'h0, faultReq});
        ack;
        rc(8'h14, 32'h0);
        $display("test faults done");
        finish_test;
    end
endmodule
`default_nettype wire
